// ---- hw/io_asm_pkg.sv ----
// Constants, register map and carrier types of the drive I/O assembly mapper.
// How it works
// - Byte 0 of the 26-byte drive input assembly carries, from bit 7 down, alarm, switch-on inhibited, emergency-stop, coast-stop, tripped, ready reference, ready to operate and ready to switch on.
// - Byte 1 of that assembly carries fieldbus error in bit 7, external run permit in bit 4, external control location in bit 3, over-threshold in bit 2, remote in bit 1 and reference reached in bit 0, with bits 6 and 5 zero.
// - Bytes 2-3 hold actual speed, bytes 4-5 actual torque and bytes 6 to 25 ten parameter words in order, every word low byte first.
// - The four-byte output assembly holds the control word in bytes 0-1 and reference 1 in bytes 2-3, low byte first, filled by the scanner and decoded here.
// - The four-byte pass-through input assembly holds the status word in bytes 0-1 and actual 1 in bytes 2-3, low byte first.
// - Pass-through words cross between network and drive profile with no translation or bit remapping.
package io_asm_pkg;

  // Assembly lengths and fixed byte positions.
  localparam logic [4:0] DRV_IN_LAST    = 5'd25;
  localparam logic [4:0] PT_IN_LAST     = 5'd3;
  localparam logic [4:0] PARAM_FIRST    = 5'd6;
  localparam logic [2:0] OUT_ASM_LAST   = 3'd3;
  localparam int         PARAM_WORDS    = 10;
  localparam int         MEM_AW         = 4;

  // Register bus.
  localparam int         REG_AW         = 8;
  localparam int         REG_DW         = 16;
  localparam logic [7:0] REG_PARAM_BASE = 8'h00;
  localparam logic [7:0] REG_PARAM_LAST = 8'h09;
  localparam logic [7:0] REG_CTRL       = 8'h10;
  localparam logic [7:0] REG_STATUS     = 8'h11;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h12;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h13;
  localparam logic [7:0] REG_OUT_CTRL   = 8'h14;
  localparam logic [7:0] REG_OUT_REF    = 8'h15;

  // Field positions and reset values.
  localparam int          CTRL_RX_EN_BIT = 0;
  localparam logic [15:0] CTRL_RESET     = 16'h0001;
  localparam int          IRQ_COMMIT_BIT = 0;
  localparam int          IRQ_RXERR_BIT  = 1;
  localparam int          IRQ_TXDONE_BIT = 2;
  localparam int          IRQ_W          = 3;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;

  // Which input assembly a transmit request builds.
  localparam logic TX_SEL_DRIVE = 1'b0;
  localparam logic TX_SEL_PASS  = 1'b1;

  typedef struct packed {
    logic alarm;
    logic switch_on_inhibited;
    logic estop_status;
    logic coast_stop_status;
    logic tripped;
    logic ready_reference;
    logic ready_to_operate;
    logic ready_to_switch_on;
  } flags0_s;

  typedef struct packed {
    logic fieldbus_error;
    logic ext_run_permit;
    logic ext_ctrl_location;
    logic over_threshold;
    logic remote;
    logic reference_reached;
  } flags1_s;

  typedef struct packed {
    flags0_s     flags0;
    flags1_s     flags1;
    logic [15:0] actual_speed;
    logic [15:0] actual_torque;
  } drive_status_s;

  typedef struct packed {
    logic [15:0] status_word;
    logic [15:0] actual1;
  } pass_in_s;

  typedef struct packed {
    logic [15:0] control_word;
    logic [15:0] reference1;
  } pass_out_s;

endpackage

// ---- hw/param_word_mem.sv ----
// Small parameter word memory with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module param_word_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input  wire logic          i_clock,
  input  wire logic          i_clk_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic      [DW-1:0] o_rdata_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [DW-1:0] o_rdata_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array so it maps to plain RAM; contents are undefined until written.
  always_ff @(posedge i_clock) begin
    if (i_clk_en) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule
`default_nettype wire

// ---- hw/drive_io_assembly_mapper.sv ----
// Cyclic I/O assembly packer and unpacker between a network scanner and a drive.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module drive_io_assembly_mapper
  import io_asm_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_b,
  input  wire logic                i_clk_en,
  // Register port.
  input  wire logic [REG_AW-1:0]   i_reg_addr,
  input  wire logic [REG_DW-1:0]   i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [REG_DW-1:0]   o_reg_rdata,
  output logic                     o_irq,
  // Output assembly bytes from the scanner.
  input  wire logic                i_rx_valid,
  input  wire logic                i_rx_sof,
  input  wire logic [7:0]          i_rx_data,
  // Input assembly bytes towards the scanner.
  input  wire logic                i_tx_req,
  input  wire logic                i_tx_sel,
  output logic                     o_tx_valid,
  output logic [7:0]               o_tx_data,
  output logic                     o_tx_last,
  input  wire logic                i_tx_ready,
  output logic                     o_tx_busy,
  // Drive application side.
  input  wire drive_status_s       i_drive_status,
  input  wire pass_in_s            i_pass_in,
  output pass_out_s                o_pass_out,
  output logic                     o_pass_out_strobe
);

  typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_e;

  logic              rst_meta_r;
  logic              rst_b;
  logic [15:0]       ctrl_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_set;
  logic [7:0]        commit_cnt_r;
  logic [REG_DW-1:0] rdata_nxt;
  logic              rd_param_r;
  logic [REG_DW-1:0] mem_rdata_a;
  logic [REG_DW-1:0] mem_rdata_b;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_raddr_b;
  logic [2:0]        rx_cnt_r;
  logic              rx_active_r;
  logic [23:0]       rx_shadow_r;
  logic              rx_commit;
  logic              rx_error;
  tx_state_e         tx_state_r;
  logic              tx_sel_r;
  logic [4:0]        tx_idx_r;
  logic [4:0]        tx_idx_nxt;
  logic              tx_fire;
  logic              tx_done;
  drive_status_s     drv_snap_r;
  pass_in_s          pass_snap_r;
  logic [7:0]        drv_byte;
  logic [7:0]        pass_byte;
  logic [4:0]        word_off;

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_r <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b      <= rst_meta_r;
    end
  end

  // Parameter words live in memory; software writes them, transmit reads them.
  assign mem_we = i_reg_wr && (i_reg_addr <= REG_PARAM_LAST);

  // Port a serves register reads, port b follows the transmit index.
  param_word_mem #(
    .AW (MEM_AW),
    .DW (REG_DW)
  ) u_param_mem (
    .i_clock   (i_clock),
    .i_clk_en  (i_clk_en),
    .i_we      (mem_we),
    .i_waddr   (i_reg_addr[MEM_AW-1:0]),
    .i_wdata   (i_reg_wdata),
    .i_raddr_a (i_reg_addr[MEM_AW-1:0]),
    .o_rdata_a (mem_rdata_a),
    .i_raddr_b (mem_raddr_b),
    .o_rdata_b (mem_rdata_b)
  );

  // Control register and interrupt mask writes.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r     <= CTRL_RESET;
      irq_mask_r <= IRQ_RESET;
    end else if (i_clk_en && i_reg_wr) begin
      if (i_reg_addr == REG_CTRL) begin
        ctrl_r <= i_reg_wdata;
      end
      if (i_reg_addr == REG_IRQ_MASK) begin
        irq_mask_r <= i_reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky event bits; a new event in the clearing cycle survives the clear.
  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_COMMIT_BIT] = rx_commit;
    irq_set[IRQ_RXERR_BIT]  = rx_error;
    irq_set[IRQ_TXDONE_BIT] = tx_done;
  end

  // Write-one-to-clear status; the event term is ORed in last so a set always wins.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= IRQ_RESET;
    end else if (i_clk_en) begin
      if (i_reg_wr && (i_reg_addr == REG_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~i_reg_wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  assign o_irq = |(irq_stat_r & irq_mask_r);

  // Read data for registers other than the parameter words.
  always_comb begin
    case (i_reg_addr)
      REG_CTRL:     rdata_nxt = ctrl_r;
      REG_STATUS:   rdata_nxt = {7'h00, o_tx_busy, commit_cnt_r};
      REG_IRQ_STAT: rdata_nxt = {{(REG_DW-IRQ_W){1'b0}}, irq_stat_r};
      REG_IRQ_MASK: rdata_nxt = {{(REG_DW-IRQ_W){1'b0}}, irq_mask_r};
      REG_OUT_CTRL: rdata_nxt = o_pass_out.control_word;
      REG_OUT_REF:  rdata_nxt = o_pass_out.reference1;
      default:      rdata_nxt = 16'h0000;
    endcase
  end

  // Read answer one cycle after the strobe; parameter reads come from memory.
  logic [REG_DW-1:0] reg_rdata_r;
  logic              rd_valid_r;

  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 16'h0000;
      rd_param_r  <= 1'b0;
      rd_valid_r  <= 1'b0;
    end else if (i_clk_en) begin
      rd_valid_r  <= i_reg_rd;
      rd_param_r  <= i_reg_rd && (i_reg_addr <= REG_PARAM_LAST);
      reg_rdata_r <= i_reg_rd ? rdata_nxt : 16'h0000;
    end
  end

  // Zero outside the answer cycle so a stale word is never mistaken for data.
  assign o_reg_rdata = !rd_valid_r ? 16'h0000 : (rd_param_r ? mem_rdata_a : reg_rdata_r);

  // Receive: gather the first three output assembly bytes in a shadow; the fourth is applied as it arrives.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt_r    <= 3'd0;
      rx_active_r <= 1'b0;
      rx_shadow_r <= 24'h00_0000;
    end else if (i_clk_en && i_rx_valid && ctrl_r[CTRL_RX_EN_BIT]) begin
      if (i_rx_sof) begin
        rx_shadow_r[7:0] <= i_rx_data;
        rx_cnt_r         <= 3'd1;
        rx_active_r      <= 1'b1;
      end else if (rx_active_r) begin
        case (rx_cnt_r)
          3'd1:    rx_shadow_r[15:8]  <= i_rx_data;
          3'd2:    rx_shadow_r[23:16] <= i_rx_data;
          default: rx_shadow_r        <= rx_shadow_r;
        endcase
        rx_cnt_r    <= rx_cnt_r + 3'd1;
        rx_active_r <= (rx_cnt_r != OUT_ASM_LAST);
      end
    end
  end

  // Commit on the last byte; a restart mid-frame or a stray byte is an error.
  assign rx_commit = i_rx_valid && ctrl_r[CTRL_RX_EN_BIT] && rx_active_r && !i_rx_sof
                     && (rx_cnt_r == OUT_ASM_LAST);
  assign rx_error  = i_rx_valid && ctrl_r[CTRL_RX_EN_BIT]
                     && (i_rx_sof ? rx_active_r : !rx_active_r);

  // Apply the whole assembly at once, words passed on unaltered.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      o_pass_out        <= '0;
      o_pass_out_strobe <= 1'b0;
      commit_cnt_r      <= 8'h00;
    end else if (i_clk_en) begin
      o_pass_out_strobe <= rx_commit;
      if (rx_commit) begin
        o_pass_out.control_word <= rx_shadow_r[15:0];
        o_pass_out.reference1   <= {i_rx_data, rx_shadow_r[23:16]};
        commit_cnt_r            <= commit_cnt_r + 8'h01;
      end
    end
  end

  // Transmit sequencing: one byte index walks the selected assembly.
  assign tx_fire = o_tx_valid && i_tx_ready;
  assign tx_done = tx_fire && o_tx_last;

  // Index restarts on an accepted request and advances on each accepted byte but the last.
  always_comb begin
    tx_idx_nxt = tx_idx_r;
    if ((tx_state_r == TX_IDLE) && i_tx_req) begin
      tx_idx_nxt = 5'd0;
    end else if (tx_fire && !o_tx_last) begin
      tx_idx_nxt = tx_idx_r + 5'd1;
    end
  end

  // Memory address follows the next index so the word is ready with its byte.
  assign word_off    = (tx_idx_nxt < PARAM_FIRST) ? 5'd0 : (tx_idx_nxt - PARAM_FIRST);
  assign mem_raddr_b = word_off[MEM_AW:1];

  // Frame state; a request while busy is dropped, not queued, so the scanner must retry.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_r <= TX_IDLE;
      tx_idx_r   <= 5'd0;
      tx_sel_r   <= TX_SEL_DRIVE;
    end else if (i_clk_en) begin
      tx_idx_r <= tx_idx_nxt;
      case (tx_state_r)
        TX_IDLE: begin
          if (i_tx_req) begin
            tx_sel_r   <= i_tx_sel;
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_done) begin
            tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Snapshot drive values at the request so one frame is self-consistent.
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      drv_snap_r  <= '0;
      pass_snap_r <= '0;
    end else if (i_clk_en && (tx_state_r == TX_IDLE) && i_tx_req) begin
      drv_snap_r  <= i_drive_status;
      pass_snap_r <= i_pass_in;
    end
  end

  // Drive assembly byte for the current index, low byte first throughout.
  always_comb begin
    case (tx_idx_r)
      5'd0: drv_byte = drv_snap_r.flags0;
      5'd1: drv_byte = {drv_snap_r.flags1.fieldbus_error, 2'b00,
                        drv_snap_r.flags1.ext_run_permit,
                        drv_snap_r.flags1.ext_ctrl_location,
                        drv_snap_r.flags1.over_threshold,
                        drv_snap_r.flags1.remote,
                        drv_snap_r.flags1.reference_reached};
      5'd2: drv_byte = drv_snap_r.actual_speed[7:0];
      5'd3: drv_byte = drv_snap_r.actual_speed[15:8];
      5'd4: drv_byte = drv_snap_r.actual_torque[7:0];
      5'd5: drv_byte = drv_snap_r.actual_torque[15:8];
      default: drv_byte = tx_idx_r[0] ? mem_rdata_b[15:8] : mem_rdata_b[7:0];
    endcase
  end

  // Pass-through assembly byte, words copied bit for bit.
  always_comb begin
    case (tx_idx_r[1:0])
      2'd0:    pass_byte = pass_snap_r.status_word[7:0];
      2'd1:    pass_byte = pass_snap_r.status_word[15:8];
      2'd2:    pass_byte = pass_snap_r.actual1[7:0];
      default: pass_byte = pass_snap_r.actual1[15:8];
    endcase
  end

  // Outputs are selected from snapshot and memory flops only.
  assign o_tx_busy  = (tx_state_r == TX_SEND);
  assign o_tx_valid = o_tx_busy;
  assign o_tx_data  = !o_tx_busy ? 8'h00 : ((tx_sel_r == TX_SEL_PASS) ? pass_byte : drv_byte);
  assign o_tx_last  = o_tx_busy
                      && (tx_idx_r == ((tx_sel_r == TX_SEL_PASS) ? PT_IN_LAST : DRV_IN_LAST));

endmodule
`default_nettype wire

// ---- dv/io_asm_props.sv ----
// Port-level assertions for the drive I/O assembly mapper.
`timescale 1ns/1ps
`default_nettype none
module io_asm_props
  import io_asm_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_rst_b,
  input wire logic              i_reg_rd,
  input wire logic [REG_DW-1:0] o_reg_rdata,
  input wire logic              i_rx_valid,
  input wire logic              i_tx_req,
  input wire logic              i_tx_sel,
  input wire logic              o_tx_valid,
  input wire logic [7:0]        o_tx_data,
  input wire logic              o_tx_last,
  input wire logic              i_tx_ready,
  input wire logic              o_tx_busy,
  input wire pass_out_s         o_pass_out,
  input wire logic              o_pass_out_strobe
);
  logic [4:0] pos_r;
  logic       sel_r;

  // Byte position and assembly kind of the frame, so length and layout can be judged.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_r <= 5'h0;
      sel_r <= 1'b0;
    end else begin
      if (i_tx_req && !o_tx_busy)
        sel_r <= i_tx_sel;
      if (o_tx_valid && i_tx_ready)
        pos_r <= o_tx_last ? 5'h0 : pos_r + 5'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0)
    else $error("read data not zero outside a read answer");
  tx_start_a: assert property (i_tx_req && !o_tx_busy |=> o_tx_valid)
    else $error("frame did not start after request");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("byte changed while stalled");
  last_ends_a: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
    else $error("frame went on after last byte");
  frame_len_a: assert property (o_tx_last |-> pos_r == (sel_r ? PT_IN_LAST : DRV_IN_LAST))
    else $error("last byte at wrong position");
  unused_bits_a: assert property (o_tx_valid && !sel_r && pos_r == 5'd1 |-> !o_tx_data[6:5])
    else $error("unused flag bits not zero");
  out_stable_a: assert property (!o_pass_out_strobe |-> $stable(o_pass_out))
    else $error("pass-through output moved without strobe");
  strobe_pulse_a: assert property (o_pass_out_strobe |-> $past(i_rx_valid) ##1 !o_pass_out_strobe)
    else $error("strobe without final byte or longer than one cycle");
  idle_quiet_a: assert property (!o_tx_busy |-> !o_tx_valid && !o_tx_last && !o_tx_data)
    else $error("transmit outputs not quiet while idle");
endmodule

bind drive_io_assembly_mapper io_asm_props props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_rx_valid(i_rx_valid), .i_tx_req(i_tx_req), .i_tx_sel(i_tx_sel), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready), .o_tx_busy(o_tx_busy),
  .o_pass_out(o_pass_out), .o_pass_out_strobe(o_pass_out_strobe));
`default_nettype wire

// ---- dv/scanner_model.sv ----
// Network scanner model: sends output assemblies and takes input assembly bytes.
`timescale 1ns/1ps
`default_nettype none
module scanner_model (
  input  wire logic       i_clock,
  input  wire logic       i_slow,
  output logic            o_rx_valid,
  output logic            o_rx_sof,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] lfsr_r = 8'h5a;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_sof = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b1;
  end

  // A slow scanner stalls at random so held bytes get exercised.
  always @(posedge i_clock) begin
    lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    o_tx_ready <= !i_slow || lfsr_r[0];
  end

  // Sends n bytes low first; idle data shows the inverse so stale bytes never look valid.
  task automatic send(input logic [31:0] w, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      o_rx_valid <= 1'b1;
      o_rx_sof <= (i == 0);
      o_rx_data <= w[8*i +: 8];
      @(posedge i_clock);
      if (gap > 0 || i == n - 1) begin
        o_rx_valid <= 1'b0;
        o_rx_sof <= 1'b0;
        o_rx_data <= ~w[8*i +: 8];
        repeat (gap) @(posedge i_clock);
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/drive_io_assembly_mapper_bench.sv ----
// Self-checking bench for the drive I/O assembly mapper.
`timescale 1ns/1ps
`default_nettype none
module drive_io_assembly_mapper_bench
  import io_asm_pkg::*;
;
  logic clock, rst_b, reg_wr, reg_rd, rd_d, irq, rx_valid, rx_sof, tx_req, tx_sel;
  logic tx_valid, tx_last, tx_ready, tx_busy, strobe, slow, clk_en;
  logic [7:0] reg_addr, rx_data, tx_data;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] prm [10];
  logic [31:0] seed = 32'h737e_84cf;
  logic [31:0] r;
  drive_status_s drive_st;
  pass_in_s pass_in;
  pass_out_s pass_out;
  logic [15:0] rd_q [$];
  logic [8:0] tx_q [$];
  pass_out_s out_q [$];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  drive_io_assembly_mapper DUT (.i_clock(clock), .i_rst_b(rst_b), .i_clk_en(clk_en),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_irq(irq), .i_rx_valid(rx_valid), .i_rx_sof(rx_sof),
    .i_rx_data(rx_data), .i_tx_req(tx_req), .i_tx_sel(tx_sel), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .o_tx_last(tx_last), .i_tx_ready(tx_ready), .o_tx_busy(tx_busy),
    .i_drive_status(drive_st), .i_pass_in(pass_in), .o_pass_out(pass_out),
    .o_pass_out_strobe(strobe));
  scanner_model scanner (.i_clock(clock), .i_slow(slow), .o_rx_valid(rx_valid),
    .o_rx_sof(rx_sof), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

  always #2.5 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One register cycle, then an idle edge so strobes never reassert in the same step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    if (!w)
      rd_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic push16(input logic [15:0] w, input logic last);
    tx_q.push_back({1'b0, w[7:0]});
    tx_q.push_back({last, w[15:8]});
  endtask

  // Notes the expected bytes, requests a frame, then changes the inputs to prove the snapshot.
  task automatic send_tx(input logic sel, input logic extra);
    if (!sel) begin
      tx_q.push_back({1'b0, drive_st.flags0});
      tx_q.push_back({1'b0, drive_st.flags1[5], 2'b00, drive_st.flags1[4:0]});
      push16(drive_st.actual_speed, 1'b0);
      push16(drive_st.actual_torque, 1'b0);
      for (int i = 0; i < PARAM_WORDS; i++)
        push16(prm[i], i == PARAM_WORDS - 1);
    end else begin
      push16(pass_in.status_word, 1'b0);
      push16(pass_in.actual1, 1'b1);
    end
    tx_sel <= sel;
    tx_req <= 1'b1;
    @(posedge clock);
    tx_req <= 1'b0;
    r = rnd();
    drive_st <= {r, r[13:0]};
    pass_in <= ~r;
    // A request while busy must be ignored; extra bytes would find no note.
    if (extra) begin
      @(posedge clock);
      tx_sel <= 1'b0;
      tx_req <= 1'b1;
      @(posedge clock);
      tx_req <= 1'b0;
    end
    // Let the request edge pass first; a frame that never ends counts as a mismatch.
    for (int i = 0; i < 300 && (tx_busy !== 1'b0 || i == 0); i++)
      @(posedge clock);
    check(tx_busy, 1'b0, "frame end");
    check(tx_q.size(), 0, "bytes missing");
  endtask

  // Result watchers take the oldest note whenever a result shows.
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d)
      check(reg_rdata, rd_q.pop_front(), "read");
    if (strobe)
      check(pass_out, out_q.pop_front(), "pass out");
    if (tx_valid && tx_ready)
      check({tx_last, tx_data}, tx_q.pop_front(), "tx byte");
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    {clock, rst_b, reg_wr, reg_rd, tx_req, tx_sel, slow} = '0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    r = rnd();
    drive_st = {r, r[13:0]};
    pass_in = ~r;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    bus(0, REG_CTRL, CTRL_RESET);
    bus(0, REG_IRQ_STAT, 16'h0000);
    bus(0, REG_STATUS, 16'h0000);
    bus(0, 8'h20, 16'h0000);
    for (int i = 0; i < PARAM_WORDS; i++) begin
      r = rnd();
      prm[i] = r[15:0];
      bus(1, REG_PARAM_BASE + 8'(i), prm[i]);
    end
    bus(0, REG_PARAM_LAST, prm[9]);
    bus(1, REG_IRQ_MASK, 16'h0001);
    // Frame bytes back to back and spaced; both bytes of each word must come from one frame.
    for (int g = 0; g < 3; g++) begin
      r = rnd();
      out_q.push_back({r[15:0], r[31:16]});
      scanner.send(r, 4, g);
      bus(0, REG_OUT_CTRL, r[15:0]);
      bus(0, REG_OUT_REF, r[31:16]);
    end
    bus(1, REG_OUT_CTRL, ~r[15:0]);
    bus(0, REG_OUT_CTRL, r[15:0]);
    check(irq, 1'b1, "irq on commit");
    // A frame cut short by a new start must never reach the outputs.
    scanner.send(rnd(), 2, 0);
    r = rnd();
    out_q.push_back({r[15:0], r[31:16]});
    scanner.send(r, 4, 1);
    bus(0, REG_IRQ_STAT, 16'h0003);
    bus(1, REG_IRQ_STAT, 16'h0007);
    check(irq, 1'b0, "irq after clear");
    bus(1, REG_CTRL, 16'h0000);
    scanner.send(rnd(), 4, 0);
    repeat (3) @(posedge clock);
    bus(1, REG_CTRL, CTRL_RESET);
    bus(0, REG_STATUS, 16'h0004);
    slow <= 1'b1;
    send_tx(TX_SEL_DRIVE, 1'b0);
    slow <= 1'b0;
    send_tx(TX_SEL_PASS, 1'b1);
    bus(1, REG_IRQ_MASK, 16'h0004);
    check(irq, 1'b1, "irq on tx done");
    // Clock enable low freezes all state but the reset synchroniser, so this clear must not land.
    clk_en <= 1'b0;
    bus(1, REG_IRQ_STAT, 16'h0004);
    clk_en <= 1'b1;
    bus(0, REG_IRQ_STAT, 16'h0004);
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule
`default_nettype wire
